/* File: verification/arseq_breaker_model.sv */
// Behavioural breaker: closes after a mechanism delay, opens on any trip
`default_nettype none
module arseq_breaker_model (
    input  wire logic clk_in,
    input  wire logic resetn_in,
    input  wire logic close_in,
    input  wire logic trip_in,
    output logic      closed_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] dly;
    // Mechanism delay keeps the close command visible for a few cycles
    always_ff @(posedge clk_in)
    begin
        if (!resetn_in)
        begin
            closed_out <= 1'b1;
            dly        <= 2'h0;
        end
        else
        begin
            dly <= close_in ? dly + 2'h1 : 2'h0;
            if (trip_in)
                closed_out <= 1'b0;
            else if (close_in && dly == 2'h3)
                closed_out <= 1'b1;
        end
    end
endmodule
`default_nettype wire

/* File: verification/arseq_tb_top.sv */
// Testbench for the autoreclose sequencer
`default_nettype none
module arseq_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import arseq_pkg::*;
    logic        clk = 1'b0, rstn = 1'b0, awv = 1'b0, wv = 1'b0, br = 1'b0;
    logic        arv = 1'b0, rr = 1'b0, tp3 = 1'b0, eok = 1'b1, syn = 1'b0;
    logic        blk = 1'b0, man = 1'b0;
    logic [7:0]  awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0;
    logic [2:0]  ph = 3'h0;
    logic [3:0]  pop = 4'h0;
    logic        awr, wr_rdy, bv, arr, rv, cls, lo, sp, tp, bcl;
    logic [1:0]  rresp, bresp;
    logic [31:0] rd;
    int          mismatches = 0, n_checks = 0;
    ////////////////////////////////////////////////////////////////////////////
    arseq_top #(.TICK_CNT(4)) i_arseq_top (.mclk_in(clk), .resetn_in(rstn),
        .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
        .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wv),
        .s_axi_wready_out(wr_rdy), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv),
        .s_axi_bready_in(br), .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv),
        .s_axi_arready_out(arr), .s_axi_rdata_out(rd), .s_axi_rresp_out(rresp),
        .s_axi_rvalid_out(rv), .s_axi_rready_in(rr), .phase_trip_in(ph),
        .three_phase_trip_in(tp3), .trip_rising_edge_select_in(pop), .breaker_closed_in(bcl),
        .breaker_energy_ok_in(eok), .sync_ok_in(syn), .dead_line_live_bus_in(1'b0),
        .live_line_dead_bus_in(1'b0), .block_reclose_in(blk), .lockout_reset_in(1'b0),
        .breaker_close_out(cls), .force_three_pole_trip_out(),
        .reclose_lockout_alarm_out(lo), .unhealthy_alarm_out(),
        .single_pole_cycle_active_out(sp), .three_pole_cycle_active_out(tp),
        .single_pole_mode_active_out(), .three_pole_mode_active_out());
    arseq_breaker_model i_arseq_breaker_model (.clk_in(clk), .resetn_in(rstn),
        .close_in(cls | man), .trip_in(|ph | tp3), .closed_out(bcl));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic neg(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        do @(negedge clk); while (awr !== 1'b1);
        @(posedge clk);
        awv <= 1'b0;
        wv <= 1'b0;
        do @(negedge clk); while (bv !== 1'b1);
        chk({30'h0, bresp}, {30'h0, RESP_OKAY});
        @(posedge clk);
        br <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        do @(negedge clk); while (arr !== 1'b1);
        @(posedge clk);
        arv <= 1'b0;
        do @(negedge clk); while (rv !== 1'b1);
        chk(rd, e);
        chk({30'h0, rresp}, {30'h0, er});
        @(posedge clk);
        rr <= 1'b0;
    endtask
    // Fault levels stay up for a while so the fault type settles before release
    task automatic trip(input logic [2:0] p, input logic t);
        @(posedge clk);
        ph <= p;
        tp3 <= t;
        pop <= {3'h0, |p | t};
    endtask
    task automatic finish_test;
        if (mismatches == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
        forever #50 clk = ~clk;
    initial
    begin
        #3_000_000;
        mismatches++;
        finish_test;
    end
    initial
    begin
        cyc(16);
        rstn <= 1'b1;
        cyc(4);
        rd_chk(OFS_CTRL, CTRL_RST, RESP_OKAY);
        rd_chk(OFS_SHOTS, SHOTS_RST, RESP_OKAY);
        rd_chk(8'h40, 32'h0, RESP_SLVERR);
        wr(OFS_DEAD1P, 32'h5);
        wr(OFS_DEAD3P1, 32'h5);
        wr(OFS_RECLAIM, 32'ha);
        wr(OFS_HEALTHY, 32'h8);
        trip(3'h1, 1'b0);
        neg(6);
        chk({30'h0, sp, tp}, 32'h2);
        trip(3'h0, 1'b0);
        wait (cls === 1'b1);
        neg(0);
        chk({31'h0, sp}, 32'h0);
        wait (bcl === 1'b1);
        neg(4);
        chk({31'h0, cls}, 32'h0);
        cyc(70);
        rd_chk(OFS_TOTAL, 32'h1, RESP_OKAY);
        eok <= 1'b0;
        syn <= 1'b1;
        trip(3'h7, 1'b1);
        neg(6);
        chk({30'h0, sp, tp}, 32'h1);
        trip(3'h0, 1'b0);
        neg(30);
        chk({31'h0, cls}, 32'h0);
        @(posedge clk);
        eok <= 1'b1;
        wait (bcl === 1'b1);
        cyc(6);
        trip(3'h7, 1'b1);
        neg(8);
        chk({30'h0, cls, lo}, 32'h1);
        trip(3'h0, 1'b0);
        neg(60);
        chk({30'h0, cls, lo}, 32'h1);
        rd_chk(OFS_TOTAL, 32'h2, RESP_OKAY);
        wr(OFS_CMD, 32'h1);
        neg(4);
        chk({31'h0, lo}, 32'h0);
        wr(OFS_CMD, 32'h2);
        rd_chk(OFS_TOTAL, 32'h0, RESP_OKAY);
        @(posedge clk);
        man <= 1'b1;
        wait (bcl === 1'b1);
        @(posedge clk);
        man <= 1'b0;
        cyc(4);
        trip(3'h2, 1'b0);
        cyc(6);
        blk <= 1'b1;
        neg(5);
        chk({31'h0, lo}, 32'h1);
        trip(3'h0, 1'b0);
        wr(OFS_CMD, 32'h1);
        neg(4);
        chk({31'h0, lo}, 32'h1);
        finish_test;
    end
endmodule
`default_nettype wire

/* File: verilog/arseq_pkg.sv */
// Package of constants and types for the breaker autoreclose sequencer
`default_nettype none
package arseq_pkg;
    localparam int          CLK_HZ       = 10_000_000;
    localparam int          TICK_US      = 1000;
    localparam int          TICK_CYCLES  = (CLK_HZ / 1_000_000) * TICK_US;
    localparam int          TMR_W        = 16;
    localparam int          CFG_N        = 10;
    // Byte offsets on the register bus
    localparam logic [7:0]  OFS_CTRL     = 8'h00;
    localparam logic [7:0]  OFS_SHOTS    = 8'h04;
    localparam logic [7:0]  OFS_FUNC     = 8'h08;
    localparam logic [7:0]  OFS_DEAD1P   = 8'h0c;
    localparam logic [7:0]  OFS_DEAD3P1  = 8'h10;
    localparam logic [7:0]  OFS_RECLAIM  = 8'h20;
    localparam logic [7:0]  OFS_HEALTHY  = 8'h24;
    localparam logic [7:0]  OFS_CMD      = 8'h28;
    localparam logic [7:0]  OFS_STATUS   = 8'h2c;
    localparam logic [7:0]  OFS_TOTAL    = 8'h30;
    // Word indices of the writable configuration words
    localparam int          IX_CTRL      = 0;
    localparam int          IX_SHOTS     = 1;
    localparam int          IX_FUNC      = 2;
    localparam int          IX_DEAD1P    = 3;
    localparam int          IX_DEAD3P1   = 4;
    localparam int          IX_RECLAIM   = 8;
    localparam int          IX_HEALTHY   = 9;
    // Field positions
    localparam int          CTRL_EN1     = 0;
    localparam int          CTRL_EN3     = 1;
    localparam int          CTRL_RISE    = 2;
    localparam int          CTRL_SYSCHK  = 3;
    localparam int          CTRL_MPB     = 4;
    localparam int          SHOTS_SP     = 0;
    localparam int          SHOTS_TP     = 4;
    localparam int          CMD_LO_RST   = 0;
    localparam int          CMD_TOT_RST  = 1;
    // Reset values
    localparam logic [31:0] CTRL_RST     = 32'h0000_000f;
    localparam logic [31:0] SHOTS_RST    = 32'h0000_0011;
    localparam logic [31:0] FUNC_RST     = 32'h0000_0055;
    localparam logic [31:0] DEAD_RST     = 32'h0000_0064;
    localparam logic [31:0] RECLAIM_RST  = 32'h0000_03e8;
    localparam logic [31:0] HEALTHY_RST  = 32'h0000_01f4;
    // Per-function action, multi-phase block and bus response encodings
    localparam logic [1:0]  FN_INIT      = 2'h1;
    localparam logic [1:0]  FN_BLOCK     = 2'h2;
    localparam logic [1:0]  MPB_23       = 2'h1;
    localparam logic [1:0]  MPB_3        = 2'h2;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_DEAD    = 3'b001,
        ST_CHECK   = 3'b010,
        ST_CLOSING = 3'b011,
        ST_RECLAIM = 3'b100,
        ST_LOCKOUT = 3'b101
    } arseq_state_e;
endpackage
`default_nettype wire

/* File: verilog/arseq_top.sv */
// Breaker autoreclose sequencer with AXI4-Lite register slave
// Operation
// - Lockout raises alarm, stops recloses, reset clears it
// - Initiate only if breaker closed until trip
// - Setting picks trip rising or falling edge
// - Single pole only: first single fault starts 1P
// - Later single faults become three pole shots
// - Single pole only: multi-phase fault locks out
// - Three pole only: fault starts shot dead time
// - Three pole only: force three pole trip
// - Both modes: first fault type picks dead time
// - Both modes, multi shots: later faults forced 3P
// - Evolving fault switches to three pole dead time
// - Dead time end clears flag, close if allowed
// - Close needs healthy and synchronism or dead side
// - Close held until breaker reports closed
// - Single pole skips sync checks (healthy still needed), shot one configurable
// - Reclaim timer after close, then back to idle, or lockout if breaker open
// - Trip in reclaim advances shot or locks out
// - Sequence count increments per trip, compared
// - Count above shot limit locks out
// - Readable total reclosures with reset command
// - Per-function initiate, no action or block
// - Multi-phase setting: allow, block 2&3, block 3
// - Block input locks out a running cycle
// - Unhealthy through wait time locks out, alarm
// - Lockout reset only once block input and trip are gone
`default_nettype none
module arseq_top
    import arseq_pkg::*;
#(
    parameter int TICK_CNT = arseq_pkg::TICK_CYCLES
)(
    input  wire logic        mclk_in,
    input  wire logic        resetn_in,
    input  wire logic [7:0]  s_axi_awaddr_in,
    input  wire logic        s_axi_awvalid_in,
    output logic             s_axi_awready_out,
    input  wire logic [31:0] s_axi_wdata_in,
    input  wire logic [3:0]  s_axi_wstrb_in,
    input  wire logic        s_axi_wvalid_in,
    output logic             s_axi_wready_out,
    output logic [1:0]       s_axi_bresp_out,
    output logic             s_axi_bvalid_out,
    input  wire logic        s_axi_bready_in,
    input  wire logic [7:0]  s_axi_araddr_in,
    input  wire logic        s_axi_arvalid_in,
    output logic             s_axi_arready_out,
    output logic [31:0]      s_axi_rdata_out,
    output logic [1:0]       s_axi_rresp_out,
    output logic             s_axi_rvalid_out,
    input  wire logic        s_axi_rready_in,
    input  wire logic [2:0]  phase_trip_in,
    input  wire logic        three_phase_trip_in,
    input  wire logic [3:0]  trip_rising_edge_select_in,
    input  wire logic        breaker_closed_in,
    input  wire logic        breaker_energy_ok_in,
    input  wire logic        sync_ok_in,
    input  wire logic        dead_line_live_bus_in,
    input  wire logic        live_line_dead_bus_in,
    input  wire logic        block_reclose_in,
    input  wire logic        lockout_reset_in,
    output logic             breaker_close_out,
    output logic             force_three_pole_trip_out,
    output logic             reclose_lockout_alarm_out,
    output logic             unhealthy_alarm_out,
    output logic             single_pole_cycle_active_out,
    output logic             three_pole_cycle_active_out,
    output logic             single_pole_mode_active_out,
    output logic             three_pole_mode_active_out
);
    import arseq_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [14:0]               meta;
        logic [14:0]               pin;
        logic                      trip_prev;
        logic                      brk_prev;
        logic                      cb_cap;
        logic [2:0]                ph_cap;
        logic                      tp_cap;
        logic [3:0]                op_cap;
        arseq_state_e              state;
        logic                      sp_shot;
        logic [2:0]                seq;
        logic [TMR_W-1:0]          tmr;
        logic [15:0]               pre;
        logic                      unhealthy;
        logic                      close;
        logic                      force3;
        logic [15:0]               total;
        logic [CFG_N-1:0][31:0]    cfg;
        logic                      bvalid;
        logic [1:0]                bresp;
        logic                      rvalid;
        logic [1:0]                rresp;
        logic [31:0]               rdata;
    } arseq_state_s;

    arseq_state_s r;
    arseq_state_s next_r;

    logic [2:0] ph;
    logic [3:0] op;
    logic       tp;
    logic       brk;
    logic       healthy;
    logic       sync_any;
    logic       blk_pin;
    logic       lo_pin;
    logic       trip_now;
    logic       rise;
    logic       evt;
    logic [2:0] e_ph;
    logic       e_tp;
    logic [3:0] e_op;
    logic       e_cb;
    logic       multi;
    logic       three;
    logic       init_f;
    logic       block_f;
    logic       mp_block;
    logic       en1;
    logic       en3;
    logic [2:0] sp_lim;
    logic [2:0] tp_lim;
    logic [2:0] cnt;
    logic       tick;
    logic       expired;
    logic       need_sync;
    logic       in_prog;
    logic       wr_go;
    logic [3:0] widx;
    logic [3:0] ridx;

    ////////////////////////////////////////////////////////////////////////////
    assign {ph, tp, op, brk, healthy} = r.pin[14:5];
    assign sync_any  = |r.pin[4:2];
    assign blk_pin   = r.pin[1];
    assign lo_pin    = r.pin[0];
    assign en1       = r.cfg[IX_CTRL][CTRL_EN1];
    assign en3       = r.cfg[IX_CTRL][CTRL_EN3];
    assign sp_lim    = r.cfg[IX_SHOTS][SHOTS_SP +: 3];
    assign tp_lim    = r.cfg[IX_SHOTS][SHOTS_TP +: 3];
    assign trip_now  = (|ph) | tp;
    assign rise      = trip_now & ~r.trip_prev;
    // Falling edge works from what was captured while the trip stood
    assign evt       = r.cfg[IX_CTRL][CTRL_RISE] ? rise : (~trip_now & r.trip_prev);
    assign e_ph      = rise ? ph : r.ph_cap;
    assign e_tp      = rise ? tp : r.tp_cap;
    assign e_op      = rise ? op : r.op_cap;
    assign e_cb      = rise ? r.brk_prev : r.cb_cap;
    assign three     = e_tp | (&e_ph);
    assign multi     = three | (e_ph[0] & e_ph[1]) | (e_ph[1] & e_ph[2]) | (e_ph[0] & e_ph[2]);
    assign mp_block  = (r.cfg[IX_CTRL][CTRL_MPB +: 2] == MPB_23 && multi)
                     | (r.cfg[IX_CTRL][CTRL_MPB +: 2] == MPB_3 && three);
    assign cnt       = r.seq + 3'h1;
    assign tick      = r.pre == 16'(TICK_CNT - 1);
    assign expired   = r.tmr == '0;
    assign need_sync = ~r.sp_shot & ~(r.seq == 3'h1 & ~r.cfg[IX_CTRL][CTRL_SYSCHK]);
    assign in_prog   = r.state != ST_IDLE && r.state != ST_LOCKOUT;
    assign wr_go     = s_axi_awvalid_in & s_axi_wvalid_in & ~r.bvalid;
    assign widx      = s_axi_awaddr_in[5:2];
    assign ridx      = s_axi_araddr_in[5:2];

    always_comb
    begin
        init_f  = 1'b0;
        block_f = 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            init_f  = init_f | (e_op[i] && r.cfg[IX_FUNC][2*i +: 2] == FN_INIT);
            block_f = block_f | (e_op[i] && r.cfg[IX_FUNC][2*i +: 2] == FN_BLOCK);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_r = r;
        next_r.meta = {phase_trip_in, three_phase_trip_in, trip_rising_edge_select_in, breaker_closed_in,
                       breaker_energy_ok_in, sync_ok_in, dead_line_live_bus_in,
                       live_line_dead_bus_in, block_reclose_in, lockout_reset_in};
        next_r.pin       = r.meta;
        next_r.trip_prev = trip_now;
        next_r.brk_prev  = brk;
        if (rise)
        begin
            next_r.cb_cap = r.brk_prev;
            next_r.ph_cap = ph;
            next_r.tp_cap = tp;
            next_r.op_cap = op;
        end
        else if (trip_now)
        begin
            next_r.ph_cap = r.ph_cap | ph;
            next_r.tp_cap = r.tp_cap | tp;
            next_r.op_cap = r.op_cap | op;
        end
        // One prescaler shared by every timer keeps the timer words short
        next_r.pre = tick ? '0 : r.pre + 16'h1;
        if (tick && !expired)
            next_r.tmr = r.tmr - 1'b1;

        case (r.state)
            ST_IDLE, ST_RECLAIM:
            begin
                if (r.state == ST_RECLAIM && expired)
                begin
                    next_r.seq   = '0;
                    next_r.state = brk ? ST_IDLE : ST_LOCKOUT;
                end
                if (evt && (e_cb || r.state == ST_RECLAIM) && (init_f || block_f))
                begin
                    next_r.seq = cnt;
                    if (block_f || mp_block || blk_pin || !(en1 || en3))
                        next_r.state = ST_LOCKOUT;
                    else if (multi && !en3)
                        next_r.state = ST_LOCKOUT;
                    else if ((!multi && cnt > sp_lim) || (multi && cnt > tp_lim) || cnt > 3'h4)
                        next_r.state = ST_LOCKOUT;
                    else if (!multi && !r.force3 && en1)
                    begin
                        next_r.state   = ST_DEAD;
                        next_r.sp_shot = 1'b1;
                        next_r.tmr     = r.cfg[IX_DEAD1P][TMR_W-1:0];
                    end
                    else
                    begin
                        next_r.state   = ST_DEAD;
                        next_r.sp_shot = 1'b0;
                        next_r.tmr     = r.cfg[IX_DEAD3P1 + 32'(r.seq)][TMR_W-1:0];
                    end
                end
            end
            ST_DEAD:
            begin
                if (r.sp_shot && evt && multi)
                begin
                    if (en3 && !mp_block)
                    begin
                        next_r.sp_shot = 1'b0;
                        next_r.tmr     = r.cfg[IX_DEAD3P1][TMR_W-1:0];
                    end
                    else
                        next_r.state = ST_LOCKOUT;
                end
                else if (expired)
                begin
                    next_r.state = ST_CHECK;
                    next_r.tmr   = r.cfg[IX_HEALTHY][TMR_W-1:0];
                end
            end
            ST_CHECK:
            begin
                if (healthy && (!need_sync || sync_any))
                begin
                    next_r.state = ST_CLOSING;
                    next_r.close = 1'b1;
                end
                else if (expired)
                begin
                    next_r.state     = ST_LOCKOUT;
                    next_r.unhealthy = !healthy;
                end
            end
            ST_CLOSING:
            begin
                if (brk)
                begin
                    next_r.close = 1'b0;
                    next_r.state = ST_RECLAIM;
                    next_r.total = r.total + 16'h1;
                    next_r.tmr   = r.cfg[IX_RECLAIM][TMR_W-1:0];
                end
            end
            ST_LOCKOUT:
            begin
                next_r.close = 1'b0;
                if ((lo_pin || (wr_go && s_axi_awaddr_in == OFS_CMD && s_axi_wstrb_in[0]
                     && s_axi_wdata_in[CMD_LO_RST])) && !blk_pin && !trip_now)
                begin
                    next_r.state     = ST_IDLE;
                    next_r.seq       = '0;
                    next_r.unhealthy = 1'b0;
                end
            end
            default:
                next_r.state = ST_LOCKOUT;
        endcase
        if (in_prog && blk_pin)
        begin
            next_r.state = ST_LOCKOUT;
            next_r.close = 1'b0;
        end
        if (next_r.state == ST_LOCKOUT)
            next_r.close = 1'b0;
        // A started sequence (seq non-zero) with a shot limit above one holds force3 so any later trip is three pole
        next_r.force3 = (en3 && !en1)
                      || (next_r.seq != '0 && ((en1 && !en3 && sp_lim > 3'h1)
                      || (en1 && en3 && tp_lim > 3'h1)));

        // Register bus: write takes address and data together
        if (wr_go)
        begin
            next_r.bvalid = 1'b1;
            next_r.bresp  = RESP_OKAY;
            // Upper address bits must be zero or a high alias would hit a config word
            if (s_axi_awaddr_in[7:6] == 2'h0 && s_axi_awaddr_in[1:0] == 2'h0
                && 32'(widx) < CFG_N)
            begin
                for (int b = 0; b < 4; b++)
                begin
                    if (s_axi_wstrb_in[b])
                        next_r.cfg[widx][8*b +: 8] = s_axi_wdata_in[8*b +: 8];
                end
            end
            else if (s_axi_awaddr_in == OFS_CMD)
            begin
                if (s_axi_wstrb_in[0] && s_axi_wdata_in[CMD_TOT_RST])
                    next_r.total = '0;
            end
            else
                next_r.bresp = RESP_SLVERR;
        end
        else if (r.bvalid && s_axi_bready_in)
            next_r.bvalid = 1'b0;
        if (s_axi_arvalid_in && !r.rvalid)
        begin
            next_r.rvalid = 1'b1;
            next_r.rresp  = RESP_OKAY;
            next_r.rdata  = '0;
            if (s_axi_araddr_in[7:6] == 2'h0 && s_axi_araddr_in[1:0] == 2'h0
                && 32'(ridx) < CFG_N)
                next_r.rdata = r.cfg[ridx];
            else if (s_axi_araddr_in == OFS_CMD)
                next_r.rdata = '0;
            else if (s_axi_araddr_in == OFS_STATUS)
                next_r.rdata = {20'h0, r.seq, r.unhealthy, r.force3, r.close,
                                r.sp_shot, r.state == ST_LOCKOUT, 1'b0, r.state};
            else if (s_axi_araddr_in == OFS_TOTAL)
                next_r.rdata = {16'h0, r.total};
            else
                next_r.rresp = RESP_SLVERR;
        end
        else if (r.rvalid && s_axi_rready_in)
            next_r.rvalid = 1'b0;

        if (!resetn_in)
        begin
            next_r                    = '0;
            next_r.state              = ST_IDLE;
            next_r.cfg[IX_CTRL]       = CTRL_RST;
            next_r.cfg[IX_SHOTS]      = SHOTS_RST;
            next_r.cfg[IX_FUNC]       = FUNC_RST;
            for (int d = IX_DEAD1P; d < IX_RECLAIM; d++)
                next_r.cfg[d]         = DEAD_RST;
            next_r.cfg[IX_RECLAIM]    = RECLAIM_RST;
            next_r.cfg[IX_HEALTHY]    = HEALTHY_RST;
        end
    end

    always_ff @(posedge mclk_in)
    begin
        r <= next_r;
    end

    ////////////////////////////////////////////////////////////////////////////
    assign s_axi_awready_out            = wr_go;
    assign s_axi_wready_out             = wr_go;
    assign s_axi_bvalid_out             = r.bvalid;
    assign s_axi_bresp_out              = r.bresp;
    assign s_axi_arready_out            = ~r.rvalid;
    assign s_axi_rvalid_out             = r.rvalid;
    assign s_axi_rresp_out              = r.rresp;
    assign s_axi_rdata_out              = r.rdata;
    assign breaker_close_out            = r.close;
    assign force_three_pole_trip_out    = r.force3;
    assign reclose_lockout_alarm_out    = r.state == ST_LOCKOUT;
    assign unhealthy_alarm_out          = r.unhealthy;
    assign single_pole_cycle_active_out = r.state == ST_DEAD && r.sp_shot;
    assign three_pole_cycle_active_out  = r.state == ST_DEAD && !r.sp_shot;
    assign single_pole_mode_active_out  = en1;
    assign three_pole_mode_active_out   = en3;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!resetn_in);

    property p_lockout_quiet;
        r.state == ST_LOCKOUT |-> reclose_lockout_alarm_out && !breaker_close_out;
    endproperty
    a_lockout_quiet: assert property (p_lockout_quiet) else $error("lockout closes");

    property p_close_hold;
        breaker_close_out && !brk && !blk_pin |=> breaker_close_out;
    endproperty
    a_close_hold: assert property (p_close_hold) else $error("close dropped");

    property p_close_drop;
        r.state == ST_CLOSING && brk |=> !breaker_close_out ##1 r.state != ST_CLOSING;
    endproperty
    a_close_drop: assert property (p_close_drop) else $error("close not removed");

    property p_close_cause;
        $rose(breaker_close_out) |-> $past(healthy) && $past(r.state) == ST_CHECK;
    endproperty
    a_close_cause: assert property (p_close_cause) else $error("close without healthy");

    property p_force3;
        en3 && !en1 ##1 $stable(r.cfg[IX_CTRL]) |-> force_three_pole_trip_out;
    endproperty
    a_force3: assert property (p_force3) else $error("force three pole missing");

    property p_block;
        in_prog && blk_pin |=> r.state == ST_LOCKOUT;
    endproperty
    a_block: assert property (p_block) else $error("block did not lock out");

    property p_flags;
        !(single_pole_cycle_active_out && three_pole_cycle_active_out);
    endproperty
    a_flags: assert property (p_flags) else $error("both cycle flags");

    property p_reclaim_end;
        r.state == ST_RECLAIM ##1 r.state == ST_IDLE |-> r.seq == '0;
    endproperty
    a_reclaim_end: assert property (p_reclaim_end) else $error("count not cleared");

    property p_total;
        r.state == ST_CLOSING && brk && !wr_go |=> r.total == $past(r.total) + 16'h1;
    endproperty
    a_total: assert property (p_total) else $error("total not counted");

    property p_unhealthy;
        r.state == ST_CHECK && expired && !healthy && !blk_pin
            |=> r.state == ST_LOCKOUT && unhealthy_alarm_out;
    endproperty
    a_unhealthy: assert property (p_unhealthy) else $error("unhealthy not latched");
endmodule
`default_nettype wire
